// ### inc/cod_pkg.sv
package cod_pkg;
  localparam int W = 16;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int NREG = 16;
  // register map
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFF_PC = 8'h08;
  localparam logic [APB_AW-1:0] OFF_STATUS_WORD = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_MADDR = 8'h10;
  localparam logic [APB_AW-1:0] OFF_MDATA = 8'h14;
  localparam logic [APB_AW-1:0] OFF_RSEL = 8'h18;
  localparam logic [APB_AW-1:0] OFF_RDATA = 8'h1C;
  localparam logic [APB_AW-1:0] OFF_INSTR = 8'h20;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FW = 1;
  localparam int CTRL_STEP = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_PRIV = 1;
  localparam int ST_ILL = 2;
  localparam int ST_FIXED = 3;
  localparam int ST_LOCK = 4;
  // instruction fields, bit 0 of the word is its least significant bit
  localparam int F_FMT = 0;
  localparam int F_SRC_LO = 1;
  localparam int F_MODE_LO = 5;
  localparam int F_DST_LO = 7;
  localparam int F_TOP_LO = 8;
  localparam int F_TOP5_LO = 11;
  localparam int F_KONST_W = 7;
  localparam logic [1:0] MODE_REG = 2'b00;
  localparam logic [1:0] MODE_CONST = 2'b01;
  localparam logic [1:0] MODE_DIRECT = 2'b10;
  localparam logic [1:0] MODE_INDIRECT = 2'b11;
  localparam logic [7:0] OPC_SET_BIT = 8'hC0;
  localparam logic [7:0] OPC_CLR_BIT = 8'hC8;
  localparam logic [7:0] OPC_PROBE_BIT = 8'hD0;
  localparam logic [7:0] OPC_FIXED_TRAP = 8'h68;
  localparam logic [7:0] OPC_MONITOR = 8'h0E;
  localparam logic [7:0] OPC_FW_RETURN = 8'h0F;
  localparam logic [7:0] OPC_HALT = 8'h0D;
  localparam logic [4:0] OPC_LEA = 5'b11110;
  localparam logic [4:0] OPC_LOAD = 5'b00100;
  localparam logic [4:0] OPC_STORE = 5'b00101;
  localparam logic [4:0] OPC_LOADK = 5'b00110;
  localparam logic [4:0] OPC_XLOAD = 5'b00111;
  localparam logic [4:0] OPC_XSTORE = 5'b01001;
  // status word layout
  localparam int SW_USER = 0;
  localparam int SW_IEN = 7;
  localparam int SW_CC_LO = 8;
  localparam int SW_LVL_LO = 10;
  localparam logic [1:0] CC_ZERO = 2'b00;
  localparam logic [1:0] CC_ONE = 2'b01;
  localparam logic [3:0] SP_IDX = 4'hF;
  localparam logic [3:0] BIT_IDX_REG = 4'h2;
  localparam logic [3:0] NO_REG = 4'h0;
  localparam logic [W-1:0] VEC_ADDR = 16'h007C;
  localparam logic [W-1:0] PC_STEP = 16'h0002;
  localparam logic [W-1:0] SAVE_GAP = 16'h0002;
  localparam logic [W-1:0] SP_DROP = 16'h0004;
  localparam logic [W-1:0] PC_RST = 16'h0000;
  localparam logic [W-1:0] SW_RST = 16'h0000;
  localparam logic [W-1:0] ZERO_W = 16'h0000;
  localparam logic [W-1:0] ONE_W = 16'h0001;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DECODE = 3'b001,
    S_EXT = 3'b010,
    S_INDIR = 3'b011,
    S_EXEC = 3'b100,
    S_TRAP_PC = 3'b101,
    S_TRAP_SW = 3'b110
  } cod_state_t;
endpackage

// ### rtl/cod_core.sv
`timescale 1ns/1ps
`default_nettype none
module cod_core (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cod_pkg::APB_AW-1:0] PADDR,
  input wire logic [cod_pkg::APB_DW-1:0] PWDATA,
  output logic [cod_pkg::APB_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic BUS_LOCK
);
  import cod_pkg::*;

  cod_state_t state_q, state_d;
  logic [W-1:0] pc_q, pc_d, ipc_q, ipc_d, instr_q, instr_d, ea_q, ea_d;
  logic direct_q, direct_d;
  logic [W-1:0] mem [MEM_DEPTH];
  logic [W-1:0] rf [NREG];
  logic [W-1:0] sw_q;
  logic run_q, step_q, fw_q;
  logic priv_q, ill_q, fixed_q, lock_q;
  logic [W-1:0] maddr_q, prdata_q;
  logic [3:0] rsel_q;

  // decode fields
  logic [7:0] top8;
  logic [4:0] top5;
  logic [1:0] mode;
  logic [3:0] src, dst;
  logic fmt, user, is_bit, is_set, is_clr, is_lea, is_load, is_store, is_loadk;
  logic is_xload, is_xstore, is_mon, is_fwret, is_halt, is_fixed, is_mem_op;
  logic needs_ext, bad_mode, priv_hit, ill_hit;
  logic [W-1:0] idx, sp_val;

  assign top8 = instr_q[F_TOP_LO +: 8];
  assign top5 = instr_q[F_TOP5_LO +: 5];
  assign mode = instr_q[F_MODE_LO +: 2];
  assign src = instr_q[F_SRC_LO +: 4];
  assign dst = instr_q[F_DST_LO +: 4];
  assign fmt = instr_q[F_FMT];
  assign user = sw_q[SW_USER];
  assign sp_val = rf[SP_IDX];
  assign idx = (src != NO_REG) ? rf[src] : ZERO_W;

  assign is_set = fmt && !instr_q[F_DST_LO] && top8 == OPC_SET_BIT;
  assign is_clr = fmt && !instr_q[F_DST_LO] && top8 == OPC_CLR_BIT;
  assign is_bit = is_set || is_clr || (fmt && !instr_q[F_DST_LO] && top8 == OPC_PROBE_BIT);
  assign is_lea = !fmt && top5 == OPC_LEA && mode == MODE_REG;
  assign is_load = fmt && top5 == OPC_LOAD;
  assign is_store = fmt && top5 == OPC_STORE;
  assign is_loadk = !fmt && top5 == OPC_LOADK;
  assign is_xload = fmt && top5 == OPC_XLOAD && mode == MODE_CONST && src == NO_REG;
  assign is_xstore = fmt && top5 == OPC_XSTORE && mode == MODE_CONST && src == NO_REG;
  assign is_mon = !fmt && top8 == OPC_MONITOR;
  assign is_fwret = !fmt && top8 == OPC_FW_RETURN;
  assign is_halt = !fmt && top8 == OPC_HALT;
  assign is_fixed = top8 == OPC_FIXED_TRAP;
  assign is_mem_op = is_load || is_store || is_bit;

  // bit strings need an address; stores cannot target a constant
  assign bad_mode = (is_bit && (mode == MODE_REG || (mode == MODE_CONST && src == NO_REG)))
                 || (is_store && mode == MODE_CONST && src == NO_REG);
  // short format other than lea, and register or register-address forms skip the extension word
  assign needs_ext = is_lea || is_xload || is_xstore
                  || (is_mem_op && mode != MODE_REG && !(mode == MODE_CONST && src != NO_REG));
  // a short-format constant overlaps the mode and register fields,
  // so there only the destination can name the stack pointer
  logic sp_named;
  assign sp_named = dst == SP_IDX || (!is_loadk && mode != MODE_CONST && src == SP_IDX);
  assign priv_hit = (user && (is_load || is_store || is_loadk) && sp_named)
                 || (user && is_lea && dst == SP_IDX)
                 || (!fw_q && (is_xload || is_xstore || is_fwret));
  assign ill_hit = bad_mode || (is_lea && dst == NO_REG)
                || !(is_mem_op || is_lea || is_loadk || is_xload || is_xstore
                     || is_mon || is_fwret || is_halt);

  // memory read ports
  logic [W-1:0] mem_at_pc, mem_at_ea, mem_at_bit, mem_at_vec, mem_at_maddr, operand;
  logic [W-1:0] bit_byte, set_word, clr_word;
  logic [3:0] bit_pos;
  logic bit_val;
  assign mem_at_pc = mem[pc_q[MEM_AW:1]];
  assign mem_at_ea = mem[ea_q[MEM_AW:1]];
  assign mem_at_vec = mem[VEC_ADDR[MEM_AW:1]];
  assign mem_at_maddr = mem[maddr_q[MEM_AW:1]];
  assign operand = direct_q ? ea_q : mem_at_ea;
  assign bit_byte = ea_q + {3'b000, rf[BIT_IDX_REG][W-1:3]};
  assign mem_at_bit = mem[bit_byte[MEM_AW:1]];
  assign bit_pos = {~bit_byte[0], 3'b111} - {1'b0, rf[BIT_IDX_REG][2:0]};
  assign bit_val = mem_at_bit[bit_pos];
  assign set_word = mem_at_bit | (ONE_W << bit_pos);
  assign clr_word = mem_at_bit & ~(ONE_W << bit_pos);

  // core actions
  logic mem_we, rf_we, sw_we, stop_priv, stop_ill, fixed_hit, halt_hit, fw_clr, fetch;
  logic [W-1:0] mem_wa, mem_wd, rf_wd, sw_wd;
  logic [3:0] rf_wa;
  assign fetch = state_q == S_IDLE && (run_q || step_q);

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    ipc_d = ipc_q;
    instr_d = instr_q;
    ea_d = ea_q;
    direct_d = direct_q;
    mem_we = 1'b0;
    mem_wa = ea_q;
    mem_wd = ZERO_W;
    rf_we = 1'b0;
    rf_wa = dst;
    rf_wd = ZERO_W;
    sw_we = 1'b0;
    sw_wd = sw_q;
    stop_priv = 1'b0;
    stop_ill = 1'b0;
    fixed_hit = 1'b0;
    halt_hit = 1'b0;
    fw_clr = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (fetch) begin
          instr_d = mem_at_pc;
          ipc_d = pc_q;
          pc_d = pc_q + PC_STEP;
          state_d = S_DECODE;
        end
      end
      S_DECODE: begin
        state_d = S_IDLE;
        direct_d = is_mem_op && (mode == MODE_REG || (mode == MODE_CONST && src == NO_REG));
        if (is_fixed) begin
          fixed_hit = 1'b1;
          state_d = S_TRAP_PC;
        end else if (priv_hit) begin
          stop_priv = 1'b1;
        end else if (ill_hit) begin
          stop_ill = 1'b1;
        end else if (is_loadk) begin
          rf_we = 1'b1;
          rf_wd = {{(W-F_KONST_W){1'b0}}, instr_q[F_KONST_W-1:0]};
        end else if (is_mon) begin
          sw_we = 1'b1;
          sw_wd[SW_USER] = 1'b0;
        end else if (is_fwret) begin
          fw_clr = 1'b1;
        end else if (is_halt) begin
          halt_hit = 1'b1;
        end else if (needs_ext) begin
          state_d = S_EXT;
        end else begin
          ea_d = rf[src];
          state_d = S_EXEC;
        end
      end
      S_EXT: begin
        pc_d = pc_q + PC_STEP;
        state_d = (mode == MODE_INDIRECT) ? S_INDIR : S_EXEC;
        if (mode == MODE_CONST || is_lea && src == NO_REG) begin
          ea_d = mem_at_pc;
        end else begin
          ea_d = mem_at_pc + idx;
        end
      end
      S_INDIR: begin
        ea_d = mem_at_ea;
        state_d = S_EXEC;
      end
      S_EXEC: begin
        state_d = S_IDLE;
        if (is_load || is_xload) begin
          rf_we = 1'b1;
          rf_wd = is_xload ? mem_at_ea : operand;
        end else if (is_store && mode == MODE_REG) begin
          rf_we = 1'b1;
          rf_wa = src;
          rf_wd = rf[dst];
        end else if (is_store || is_xstore) begin
          mem_we = 1'b1;
          mem_wd = rf[dst];
        end else if (is_lea) begin
          rf_we = 1'b1;
          rf_wd = ea_q;
        end else begin
          sw_we = 1'b1;
          sw_wd[SW_CC_LO +: 2] = bit_val ? CC_ONE : CC_ZERO;
          mem_wa = bit_byte;
          mem_we = (is_set && !bit_val) || (is_clr && bit_val);
          mem_wd = is_set ? set_word : clr_word;
        end
      end
      S_TRAP_PC: begin
        mem_we = 1'b1;
        mem_wa = sp_val;
        mem_wd = ipc_q;
        state_d = S_TRAP_SW;
      end
      S_TRAP_SW: begin
        mem_we = 1'b1;
        mem_wa = sp_val - SAVE_GAP;
        mem_wd = sw_q;
        rf_we = 1'b1;
        rf_wa = SP_IDX;
        rf_wd = sp_val - SP_DROP;
        sw_we = 1'b1;
        sw_wd[SW_IEN] = 1'b0;
        sw_wd[SW_USER] = 1'b0;
        pc_d = mem_at_vec;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // APB slave
  logic acc, wr, setup, mapped, idle_ok;
  logic [W-1:0] pwdata_lo;
  // only the low half of the APB word carries data
  assign pwdata_lo = PWDATA[W-1:0];
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign setup = PSEL && !PENABLE;
  assign idle_ok = state_q == S_IDLE && !run_q && !step_q;
  assign mapped = PADDR == OFF_CTRL || PADDR == OFF_STATUS || PADDR == OFF_PC
               || PADDR == OFF_STATUS_WORD || PADDR == OFF_MADDR || PADDR == OFF_MDATA
               || PADDR == OFF_RSEL || PADDR == OFF_RDATA || PADDR == OFF_INSTR;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign PRDATA = {{(APB_DW-W){1'b0}}, prdata_q};
  assign BUS_LOCK = lock_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prdata_q <= ZERO_W;
    end else if (setup) begin
      unique case (PADDR)
        OFF_CTRL: prdata_q <= {13'h0000, 1'b0, fw_q, run_q};
        OFF_STATUS: prdata_q <= {11'h000, lock_q, fixed_q, ill_q, priv_q, !idle_ok};
        OFF_PC: prdata_q <= pc_q;
        OFF_STATUS_WORD: prdata_q <= sw_q;
        OFF_MADDR: prdata_q <= maddr_q;
        OFF_MDATA: prdata_q <= mem_at_maddr;
        OFF_RSEL: prdata_q <= {12'h000, rsel_q};
        OFF_RDATA: prdata_q <= rf[rsel_q];
        OFF_INSTR: prdata_q <= instr_q;
        default: prdata_q <= ZERO_W;
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q <= S_IDLE;
      pc_q <= PC_RST;
      ipc_q <= PC_RST;
      instr_q <= ZERO_W;
      ea_q <= ZERO_W;
      direct_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= (wr && idle_ok && PADDR == OFF_PC) ? pwdata_lo : pc_d;
      ipc_q <= ipc_d;
      instr_q <= instr_d;
      ea_q <= ea_d;
      direct_q <= direct_d;
    end
  end

  // software memory, core has priority; software writes only while stopped
  always_ff @(posedge CLOCK) begin
    if (mem_we) begin
      mem[mem_wa[MEM_AW:1]] <= mem_wd;
    end else if (wr && idle_ok && PADDR == OFF_MDATA) begin
      mem[maddr_q[MEM_AW:1]] <= pwdata_lo;
    end
  end

  // general registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int i = 0; i < NREG; i++) begin
        rf[i] <= ZERO_W;
      end
    end else if (rf_we) begin
      rf[rf_wa] <= rf_wd;
    end else if (wr && idle_ok && PADDR == OFF_RDATA) begin
      rf[rsel_q] <= pwdata_lo;
    end
  end

  // status word
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sw_q <= SW_RST;
    end else if (sw_we) begin
      sw_q <= sw_wd;
    end else if (wr && idle_ok && PADDR == OFF_STATUS_WORD) begin
      sw_q <= pwdata_lo;
    end
  end

  // control
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      run_q <= 1'b0;
      step_q <= 1'b0;
      fw_q <= 1'b0;
    end else if (wr && PADDR == OFF_CTRL) begin
      run_q <= PWDATA[CTRL_RUN];
      fw_q <= PWDATA[CTRL_FW];
      step_q <= PWDATA[CTRL_STEP];
    end else begin
      run_q <= run_q && !(stop_priv || stop_ill || halt_hit);
      fw_q <= fw_q && !fw_clr;
      step_q <= step_q && !fetch;
    end
  end

  // memory address pointer
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      maddr_q <= ZERO_W;
    end else if (wr && PADDR == OFF_MADDR) begin
      maddr_q <= pwdata_lo;
    end
  end

  // register select pointer
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rsel_q <= NO_REG;
    end else if (wr && PADDR == OFF_RSEL) begin
      rsel_q <= pwdata_lo[3:0];
    end
  end

  // sticky flags, a new event wins over a clear
  logic clr_st;
  assign clr_st = wr && PADDR == OFF_STATUS;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      priv_q <= 1'b0;
      ill_q <= 1'b0;
      fixed_q <= 1'b0;
    end else begin
      priv_q <= stop_priv || (priv_q && !(clr_st && PWDATA[ST_PRIV]));
      ill_q <= stop_ill || (ill_q && !(clr_st && PWDATA[ST_ILL]));
      fixed_q <= fixed_hit || (fixed_q && !(clr_st && PWDATA[ST_FIXED]));
    end
  end

  // bus lock held from the cycle after decode through execute of a test-and-modify
  logic lock_d;
  assign lock_d = (is_set || is_clr) && state_q != S_IDLE
      && (state_d == S_EXT || state_d == S_INDIR || state_d == S_EXEC);
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end
endmodule
`default_nettype wire

// ### sim/cod_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cod_core_properties (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cod_pkg::APB_AW-1:0] PADDR,
  input wire logic [cod_pkg::APB_DW-1:0] PWDATA,
  input wire logic [cod_pkg::APB_DW-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BUS_LOCK
);
  import cod_pkg::*;
  logic started_q;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // remembers that the core was ever told to run or step
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      started_q <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && PADDR == OFF_CTRL &&
        (PWDATA[CTRL_RUN] || PWDATA[CTRL_STEP])) begin
      started_q <= 1'b1;
    end
  end
  a_ready_in_access: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready low in access phase");
  a_err_in_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error flag outside access phase");
  a_err_unmapped: assert property (PSEL && PENABLE && PADDR > OFF_INSTR |-> PSLVERR)
    else $error("unmapped access without error");
  a_no_err_mapped: assert property (PSEL && PENABLE && PADDR <= OFF_INSTR &&
    PADDR[1:0] == 2'b00 |-> !PSLVERR) else $error("mapped access flagged");
  a_rdata_holds: assert property (PSEL && PENABLE && !PWRITE |=> $stable(PRDATA))
    else $error("read data moved after access");
  a_rdata_unmapped: assert property (PSEL && PENABLE && !PWRITE && PSLVERR |->
    PRDATA == 32'h00000000) else $error("unmapped read data not zero");
  a_rdata_upper_zero: assert property (PRDATA[APB_DW-1:W] == 16'h0000)
    else $error("read data upper half not zero");
  a_lock_released: assert property (BUS_LOCK |-> ##[1:8] !BUS_LOCK)
    else $error("bus lock held too long");
  a_lock_has_cause: assert property (BUS_LOCK |-> started_q)
    else $error("bus lock without run or step");
  c_lock: cover property ($rose(BUS_LOCK));
  c_err: cover property (PSLVERR);
  c_b2b: cover property (PSEL && PENABLE ##1 PSEL && !PENABLE);
endmodule
`default_nettype wire

// ### sim/cod_apb_master.sv
`timescale 1ns/1ps
`default_nettype none
module cod_apb_master (
  input wire logic CLOCK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [cod_pkg::APB_AW-1:0] PADDR,
  output logic [cod_pkg::APB_DW-1:0] PWDATA,
  input wire logic [cod_pkg::APB_DW-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  import cod_pkg::*;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
  end
  // setup cycle, then access held until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a,
      input logic [W-1:0] wd, output logic [W-1:0] rd, output logic err);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {{(APB_DW-W){1'b0}}, wd};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA[W-1:0];
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/cod_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cod_core_tb_top;
  import cod_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BUS_LOCK;
  logic [APB_AW-1:0] PADDR;
  logic [APB_DW-1:0] PWDATA, PRDATA;
  logic [W-1:0] rv;
  logic ev;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int lock_cycles = 0;
  localparam logic [W-1:0] INS [8] = '{16'h220D, 16'h2221, 16'h222D, 16'h2241,
    16'h224D, 16'h2261, 16'h226D, 16'h3254};
  localparam logic [W-1:0] EXT [8] = '{16'h0000, 16'hABCD, 16'h0000, 16'h0050,
    16'h0040, 16'h0060, 16'h0050, 16'h0000};
  localparam logic [W-1:0] EXP [8] = '{16'h0010, 16'hABCD, 16'h3333, 16'h1111,
    16'h1111, 16'h1111, 16'h1111, 16'h0054};
  localparam logic [W-1:0] LEN [8] = '{16'h2, 16'h4, 16'h2, 16'h4, 16'h4, 16'h4, 16'h4, 16'h2};
  always #12.5 CLOCK = ~CLOCK;
  cod_core cod_core_inst (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BUS_LOCK(BUS_LOCK));
  cod_apb_master cod_apb_master_inst (.CLOCK(CLOCK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  task automatic end_sim;
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [W-1:0] d);
    cod_apb_master_inst.xfer(1'b1, a, d, rv, ev);
  endtask
  task automatic rd(input logic [APB_AW-1:0] a);
    cod_apb_master_inst.xfer(1'b0, a, 16'h0000, rv, ev);
  endtask
  task automatic mem_wr(input logic [W-1:0] a, input logic [W-1:0] d);
    wr(OFF_MADDR, a);
    wr(OFF_MDATA, d);
  endtask
  task automatic mem_rd(input logic [W-1:0] a);
    wr(OFF_MADDR, a);
    rd(OFF_MDATA);
  endtask
  task automatic reg_wr(input logic [W-1:0] r, input logic [W-1:0] d);
    wr(OFF_RSEL, r);
    wr(OFF_RDATA, d);
  endtask
  task automatic reg_rd(input logic [W-1:0] r);
    wr(OFF_RSEL, r);
    rd(OFF_RDATA);
  endtask
  task automatic step_at(input logic [W-1:0] pc, input logic [W-1:0] ctl);
    wr(OFF_PC, pc);
    wr(OFF_CTRL, ctl);
    repeat (3) @(posedge CLOCK);
    do begin
      rd(OFF_STATUS);
    end while (rv[ST_BUSY] !== 1'b0);
  endtask
  task automatic t_reset;
    rd(OFF_CTRL);
    chk(rv, 16'h0000);
    rd(OFF_PC);
    chk(rv, PC_RST);
    rd(OFF_STATUS_WORD);
    chk(rv, SW_RST);
    rd(8'h24);
    chk(16'(ev), 16'h0001);
    chk(rv, 16'h0000);
  endtask
  task automatic t_modes;
    reg_wr(16'h0006, 16'h0010);
    mem_wr(16'h0010, 16'h3333);
    mem_wr(16'h0040, 16'h0000);
    mem_wr(16'h0050, 16'h1111);
    mem_wr(16'h0060, 16'h0050);
    for (int i = 0; i < 8; i++) begin
      mem_wr(16'h0090, INS[i]);
      mem_wr(16'h0092, EXT[i]);
      reg_wr(16'h0004, 16'h0000);
      step_at(16'h0090, 16'h0004);
      reg_rd(16'h0004);
      chk(rv, EXP[i]);
      rd(OFF_PC);
      chk(rv, 16'h0090 + LEN[i]);
    end
  endtask
  task automatic bit_step(input logic [W-1:0] pc, input logic [W-1:0] m, input logic [1:0] cc);
    step_at(pc, 16'h0004);
    mem_rd(16'h0040);
    chk(rv, m);
    rd(OFF_STATUS_WORD);
    chk(16'(rv[SW_CC_LO+:2]), 16'(cc));
  endtask
  task automatic t_bits;
    int n0;
    reg_wr(16'h0003, 16'h0040);
    reg_wr(16'h0002, 16'h0003);
    mem_wr(16'h0000, 16'hC027);
    mem_wr(16'h0002, 16'hC027);
    mem_wr(16'h0004, 16'hF286);
    mem_wr(16'h0006, 16'h0100);
    mem_wr(16'h0008, 16'hC827);
    mem_wr(16'h000A, 16'hD027);
    n0 = lock_cycles;
    bit_step(16'h0000, 16'h1000, CC_ZERO);
    chk(16'(lock_cycles > n0), 16'h0001);
    bit_step(16'h0002, 16'h1000, CC_ONE);
    bit_step(16'h0004, 16'h1000, CC_ONE);
    reg_rd(16'h0005);
    chk(rv, 16'h0140);
    bit_step(16'h0008, 16'h0000, CC_ONE);
    bit_step(16'h000A, 16'h0000, CC_ZERO);
    reg_wr(16'h0002, 16'h000B);
    bit_step(16'h0000, 16'h0010, CC_ZERO);
    bit_step(16'h000A, 16'h0010, CC_ONE);
    mem_wr(16'h0020, 16'hC861);
    mem_wr(16'h0022, 16'h0028);
    mem_wr(16'h0024, 16'hD047);
    mem_wr(16'h0026, 16'h0000);
    mem_wr(16'h0028, 16'h0040);
    n0 = lock_cycles;
    bit_step(16'h0020, 16'h0000, CC_ONE);
    chk(16'(lock_cycles > n0), 16'h0001);
    bit_step(16'h0024, 16'h0000, CC_ZERO);
  endtask
  task automatic t_trap;
    reg_wr(16'h000F, 16'h0080);
    wr(OFF_STATUS_WORD, 16'h0081);
    mem_wr(16'h000C, 16'h68A5);
    mem_wr(VEC_ADDR, 16'h0030);
    step_at(16'h000C, 16'h0004);
    chk(16'(rv[ST_FIXED]), 16'h0001);
    mem_rd(16'h0080);
    chk(rv, 16'h000C);
    mem_rd(16'h007E);
    chk(rv, 16'h0081);
    reg_rd(16'h000F);
    chk(rv, 16'h007C);
    rd(OFF_STATUS_WORD);
    chk(rv, 16'h0000);
    rd(OFF_PC);
    chk(rv, 16'h0030);
    wr(OFF_STATUS, 16'h000E);
  endtask
  task automatic t_priv;
    wr(OFF_STATUS_WORD, 16'h0001);
    mem_wr(16'h0030, 16'hF780);
    mem_wr(16'h0032, 16'h0000);
    step_at(16'h0030, 16'h0004);
    chk(16'(rv[ST_PRIV]), 16'h0001);
    reg_rd(16'h000F);
    chk(rv, 16'h007C);
    wr(OFF_STATUS, 16'h000E);
    wr(OFF_STATUS_WORD, 16'h0000);
    mem_wr(16'h0034, 16'hF000);
    mem_wr(16'h0036, 16'h0000);
    step_at(16'h0034, 16'h0004);
    chk(16'(rv[ST_ILL]), 16'h0001);
    wr(OFF_STATUS, 16'h000E);
    mem_wr(16'h0038, 16'h3A21);
    mem_wr(16'h003A, 16'h0010);
    step_at(16'h0038, 16'h0004);
    chk(16'(|rv[2:1]), 16'h0001);
    reg_rd(16'h0004);
    chk(rv, 16'h0054);
    wr(OFF_STATUS, 16'h000E);
    step_at(16'h0038, 16'h0006);
    reg_rd(16'h0004);
    chk(rv, 16'h3333);
    wr(OFF_STATUS_WORD, 16'h0001);
    mem_wr(16'h003E, 16'h321E);
    step_at(16'h003E, 16'h0004);
    chk(16'(rv[ST_PRIV]), 16'h0000);
    reg_rd(16'h0004);
    chk(rv, 16'h001E);
    mem_wr(16'h003C, 16'h0E00);
    step_at(16'h003C, 16'h0004);
    rd(OFF_STATUS_WORD);
    chk(16'(rv[SW_USER]), 16'h0000);
  endtask
  always @(posedge CLOCK) begin
    if (BUS_LOCK === 1'b1) begin
      lock_cycles++;
    end
  end
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_modes();
    t_bits();
    t_trap();
    t_priv();
    end_sim();
  end
endmodule
bind cod_core cod_core_properties cod_core_properties_inst (.CLOCK(CLOCK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_LOCK(BUS_LOCK));
`default_nettype wire
